// >>> hw/sa6_change_irq.sv
// Spare-code change interrupt: status, enable, clear registers and interrupt output.
// Assumes the register port and the multiframe strobe share i_clk.
`include "sa6_irq_consts.svh"
`default_nettype none
module sa6_change_irq
  import sa6_irq_pkg::*;
#(
  parameter int REPEAT = `SA6_DEBOUNCE_CNT
) (
  input  wire logic        i_clk,       // Framer clock, 100 MHz
  input  wire logic        i_reset_n,   // Async reset, active low
  input  wire logic [3:0]  i_raw_code,  // Raw spare code per multiframe
  input  wire logic        i_mf_strobe, // Multiframe done pulse
  input  wire logic [11:0] i_addr,      // Register address
  input  wire logic [7:0]  i_wdata,     // Write data
  input  wire logic        i_wr,        // Write strobe
  input  wire logic        i_rd,        // Read strobe
  output logic      [7:0]  o_rdata,     // Read data, cycle after i_rd
  output logic      [3:0]  o_code,      // Debounced code
  output logic             o_irq        // Level interrupt
);
  sa6_code_if deb_if ();

  sa6_debounce #(.REPEAT(REPEAT)) u_deb (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_raw_code  (i_raw_code),
    .i_mf_strobe (i_mf_strobe),
    .deb         (deb_if.src)
  );

  function automatic sa6_reg_type match_vec(input sa6_code_type c);
    sa6_reg_type m;
    m = 8'h00;
    m[`SA6_BIT_1111] = (c == 4'hf);
    m[`SA6_BIT_1110] = (c == 4'he);
    m[`SA6_BIT_1100] = (c == 4'hc);
    m[`SA6_BIT_1010] = (c == 4'ha);
    m[`SA6_BIT_1000] = (c == 4'h8);
    m[`SA6_BIT_001X] = (c[3:1] == 3'b001);
    m[`SA6_BIT_0000] = (c == 4'h0);
    m[`SA6_BIT_OTHER] = ~|m;
    return m;
  endfunction

  sa6_code_type prev_code_r;
  logic         prev_valid_r;
  sa6_reg_type  status_r;
  sa6_reg_type  enable_r;
  sa6_reg_type  status_nxt;
  sa6_reg_type  rdata_nxt;
  logic [7:0]   rdata_r;
  logic         irq_r;

  wire sa6_reg_type cur_m   = match_vec(deb_if.code);
  wire sa6_reg_type prev_m  = match_vec(prev_code_r);
  wire logic        changed = deb_if.valid && (!prev_valid_r || deb_if.code != prev_code_r);
  // Edges of a match; first debounced value counts as entering it
  wire sa6_reg_type edge_w  = changed ? ((cur_m ^ (prev_valid_r ? prev_m : 8'h00)) & ~8'h02) : 8'h00;
  wire sa6_reg_type other_w = changed ? (cur_m & 8'h02) : 8'h00;
  wire sa6_reg_type event_w = edge_w | other_w;
  wire logic        rd_stat = i_rd && (i_addr == `SA6_OFS_STATUS);
  wire logic        wr_clr  = i_wr && (i_addr == `SA6_OFS_CLEAR);
  wire logic        wr_en   = i_wr && (i_addr == `SA6_OFS_ENABLE);
  wire sa6_reg_type clr_w   = (rd_stat ? 8'hff : 8'h00) | (wr_clr ? i_wdata : 8'h00);

  // New events win over a clear in the same cycle
  assign status_nxt = (status_r & ~clr_w) | event_w;
  assign rdata_nxt  = rd_stat ? status_r :
                      (i_rd && i_addr == `SA6_OFS_ENABLE) ? enable_r : 8'h00;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prev_code_r  <= `SA6_RESET_CODE;
      prev_valid_r <= 1'b0;
      status_r     <= `SA6_RESET_REG;
      enable_r     <= `SA6_RESET_REG;
      rdata_r      <= 8'h00;
      irq_r        <= 1'b0;
    end else begin
      prev_code_r  <= deb_if.code;
      prev_valid_r <= deb_if.valid;
      status_r     <= status_nxt;
      if (wr_en) enable_r <= i_wdata;
      rdata_r      <= rdata_nxt;
      irq_r        <= |(status_nxt & enable_r);
    end
  end

  assign o_rdata = rdata_r;
  assign o_code  = prev_code_r;
  assign o_irq   = irq_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence stat_read_s;
    rd_stat && (event_w == 8'h00);
  endsequence

  status_clear_a: assert property (stat_read_s |=> status_r == 8'h00)
    else $error("status not cleared by read");
  event_wins_a: assert property (rd_stat && event_w != 8'h00 |=> (status_r & $past(event_w)) == $past(event_w))
    else $error("event lost during read");
  flag_sticky_a: assert property (!rd_stat && !wr_clr |=> (status_r & $past(status_r)) == $past(status_r))
    else $error("flag dropped without read");
  irq_gate_a: assert property (enable_r == 8'h00 && $past(enable_r) == 8'h00 |-> !o_irq)
    else $error("irq while all sources disabled");
  irq_all1_a: assert property (!rd_stat && !wr_clr && status_r[7] && enable_r[7] |=> o_irq)
    else $error("1111 irq not raised");
  irq_level_a: assert property (o_irq == |(status_r & $past(enable_r)))
    else $error("irq level differs from enabled flags");
  clear_write_a: assert property (wr_clr && !rd_stat |=> (status_r & $past(i_wdata & ~event_w)) == 8'h00)
    else $error("clear write left a flag set");
  rdata_enable_a: assert property (i_rd && i_addr == `SA6_OFS_ENABLE |=> o_rdata == $past(enable_r))
    else $error("enable readback wrong");
  irq_1110_a: assert property (status_r[6] && enable_r[6] && !$past(rd_stat) |-> ##1 o_irq || $past(rd_stat))
    else $error("1110 irq not raised");
  irq_1100_a: assert property (!rd_stat && !wr_clr && status_r[5] && enable_r[5] |=> o_irq)
    else $error("1100 irq not raised");
  zero_edge_a: assert property (changed && prev_valid_r && (cur_m[0] != prev_m[0]) |=> status_r[0])
    else $error("0000 change not flagged");
  pat001_a: assert property (changed && prev_valid_r && (cur_m[2] != prev_m[2]) |=> status_r[2])
    else $error("001x change not flagged");
  other_set_a: assert property (changed && cur_m[1] |=> status_r[1])
    else $error("other code not flagged");
  all1_edge_a: assert property (changed && prev_valid_r && (cur_m[7] != prev_m[7]) |=> status_r[7])
    else $error("1111 change not flagged");
  pat1000_a: assert property (changed && prev_valid_r && (cur_m[3] != prev_m[3]) |=> status_r[3])
    else $error("1000 change not flagged");
  pat1010_a: assert property (changed && prev_valid_r && (cur_m[4] != prev_m[4]) |=> status_r[4])
    else $error("1010 change not flagged");
  deb_hold_a: assert property (deb_if.valid && !$past(i_mf_strobe) |-> $stable(deb_if.code))
    else $error("code moved without multiframe");
endmodule // sa6_change_irq
`default_nettype wire

// >>> hw/sa6_code_if.sv
// Carries the debounced spare code from the debouncer to the event logic.
// Assumes one clock domain.
`default_nettype none
interface sa6_code_if;
  import sa6_irq_pkg::*;
  sa6_code_type code;
  logic         valid;
  modport src (output code, output valid);
  modport dst (input code, input valid);
endinterface
`default_nettype wire

// >>> hw/sa6_debounce.sv
// Debounces the raw four-bit spare code per multiframe.
// Assumes i_mf_strobe is a one-cycle pulse in the i_clk domain.
`include "sa6_irq_consts.svh"
`default_nettype none
module sa6_debounce
  import sa6_irq_pkg::*;
#(
  parameter int REPEAT = `SA6_DEBOUNCE_CNT
) (
  input  wire logic         i_clk,       // Framer clock
  input  wire logic         i_reset_n,   // Async reset, active low
  input  wire logic [3:0]   i_raw_code,  // Code of the latest multiframe
  input  wire logic         i_mf_strobe, // Multiframe done pulse
  sa6_code_if.src           deb          // Debounced code out
);
  deb_state_type state_r;
  sa6_code_type  cand_r;
  logic [3:0]    cnt_r;
  sa6_code_type  code_r;
  logic          valid_r;
  wire           same_w  = (i_raw_code == cand_r);
  wire           reach_w = same_w && (cnt_r >= 4'(REPEAT - 1));

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= DEB_IDLE;
      cand_r  <= `SA6_RESET_CODE;
      cnt_r   <= 4'h0;
      code_r  <= `SA6_RESET_CODE;
      valid_r <= 1'b0;
    end else if (i_mf_strobe) begin
      case (state_r)
        DEB_IDLE: begin
          cand_r  <= i_raw_code;
          cnt_r   <= 4'h1;
          state_r <= DEB_TRACK;
        end
        DEB_TRACK: begin
          cand_r <= i_raw_code;
          if (!same_w) cnt_r <= 4'h1;
          else if (!reach_w) cnt_r <= cnt_r + 4'h1;
          if (reach_w) begin
            code_r  <= cand_r;
            valid_r <= 1'b1;
          end
        end
        default: state_r <= DEB_IDLE;
      endcase
    end
  end

  assign deb.code  = code_r;
  assign deb.valid = valid_r;
endmodule // sa6_debounce
`default_nettype wire

// >>> hw/sa6_irq_consts.svh
// Register map, field positions and reset values of the spare-code change interrupt block.
// Assumes inclusion by bare name from the design files.
// Summary of operation
// - Flag bit 2 when the code enters or leaves 001x, low bit ignored.
// - Flag bit 1 when the code changes to a combination no watched pattern covers.
// - Flag bit 0 when the code begins or ceases to equal 0000.
// - Keep a flag for changes into or out of pattern 1000.
// - Reading the status register clears flags; later events stay until next read.
// - A flag reads 1 if its event occurred since last read; resets to 0.
// - Enable bit 7 gates the 1111 change interrupt.
// - Enable bit 6 gates the 1110 change interrupt.
// - Enable bit 5 gates the 1100 change interrupt.
// - Enable bits are read/write, reset to 0; interrupt only for enabled sources.
// - Status bits 7 and 6 record 1111 and 1110 changes; clear on read.
`ifndef SA6_IRQ_CONSTS_SVH
`define SA6_IRQ_CONSTS_SVH
`define SA6_OFS_STATUS   12'h0b0c
`define SA6_OFS_ENABLE   12'h0b0d
`define SA6_OFS_CLEAR    12'h0b0e
`define SA6_BIT_1111     3'h7
`define SA6_BIT_1110     3'h6
`define SA6_BIT_1100     3'h5
`define SA6_BIT_1010     3'h4
`define SA6_BIT_1000     3'h3
`define SA6_BIT_001X     3'h2
`define SA6_BIT_OTHER    3'h1
`define SA6_BIT_0000     3'h0
`define SA6_RESET_REG    8'h00
`define SA6_RESET_CODE   4'h0
`define SA6_DEBOUNCE_CNT 3
`endif

// >>> hw/sa6_irq_pkg.sv
// Types of the spare-code change interrupt block.
// Assumes nothing beyond the constants header.
`default_nettype none
package sa6_irq_pkg;
  typedef logic [7:0] sa6_reg_type;
  typedef logic [3:0] sa6_code_type;
  typedef enum logic [1:0] {
    DEB_IDLE  = 2'b01,
    DEB_TRACK = 2'b10
  } deb_state_type;
endpackage
`default_nettype wire

// >>> tb/sa6_src_model.sv
// Stand-in for the framer's spare-code extraction, one code per multiframe pulse.
// Assumes its caller runs in the i_clk domain.
`default_nettype none
module sa6_src_model (
  input  wire logic       i_clk,      // Framer clock
  output var  logic [3:0] o_raw,      // Code of each multiframe
  output var  logic       o_mf_strobe // Multiframe done pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_raw       = 4'h0;
    o_mf_strobe = 1'b0;
  end
  // Varying gaps give both tight and slow multiframes
  task automatic send(input logic [3:0] code, input int n);
    for (int i = 0; i < n; i++) begin
      repeat (1 + $urandom_range(2)) @(posedge i_clk);
      o_raw       <= code;
      o_mf_strobe <= 1'b1;
      @(posedge i_clk);
      o_mf_strobe <= 1'b0;
      o_raw       <= ~code; // Stale outside the pulse
    end
  endtask
endmodule // sa6_src_model
`default_nettype wire

// >>> tb/test_e1_sa6_pattern_change_irq.sv
// Self-checking bench of the spare-code change interrupt block.
// Assumes the design files and sa6_src_model are compiled first.
`include "sa6_irq_consts.svh"
`default_nettype none
module test_e1_sa6_pattern_change_irq
  import sa6_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int REP = 3;
  logic         i_clk, i_reset_n, i_wr, i_rd, rd_d, mf, o_irq;
  logic  [11:0] i_addr;
  logic  [7:0]  i_wdata, o_rdata;
  logic  [3:0]  raw, o_code;
  logic  [55:0] tbl = 56'hfe_ca82_3051_0fde;
  sa6_reg_type  exp_q[$];
  sa6_reg_type  st, en, om;
  sa6_code_type old_c, new_c;
  int           n_fail, comparisons, cyc;
  sa6_change_irq #(.REPEAT(REP)) dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_raw_code(raw), .i_mf_strobe(mf),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_code(o_code), .o_irq(o_irq));
  sa6_src_model src_u (.i_clk(i_clk), .o_raw(raw), .o_mf_strobe(mf));
  function automatic sa6_reg_type pat(input sa6_code_type c);
    pat = {c == 4'hf, c == 4'he, c == 4'hc, c == 4'ha, c == 4'h8, c[3:1] == 3'h1, 1'b0, c == 4'h0};
    pat[1] = ~|pat;
  endfunction
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    comparisons++;
    if (got !== ex) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input sa6_reg_type ex);
    exp_q.push_back(ex);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd   <= 1'b0;
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) rd_d <= i_rd;
  // Read data stand only in the cycle after the strobe
  always @(negedge i_clk) if (rd_d === 1'b1) chk("rdata", exp_q.pop_front(), o_rdata);
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    {i_reset_n, i_wr, i_rd, rd_d, i_addr, i_wdata, st, om} = '0;
    {n_fail, comparisons, cyc} = '0;
    old_c = 4'hx;
    void'($urandom(79));
    repeat (16) @(posedge i_clk);
    i_reset_n <= 1'b1;
    chk("irq", 8'h00, {7'h00, o_irq});
    rd(`SA6_OFS_STATUS, 8'h00);
    rd(`SA6_OFS_ENABLE, 8'h00);
    rd(12'h0b0f, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 14; i++) begin
      en = $urandom;
      wr(`SA6_OFS_ENABLE, en);
      rd(`SA6_OFS_ENABLE, en);
      src_u.send($urandom, REP - 1);
      new_c = tbl[55 - 4 * i -: 4];
      src_u.send(new_c, REP);
      if (new_c !== old_c)
        st = st | ((om ^ pat(new_c)) & 8'hfd) | (pat(new_c) & 8'h02);
      om = pat(new_c);
      old_c = new_c;
      repeat (4) @(posedge i_clk);
      #1;
      chk("code", {4'h0, new_c}, {4'h0, o_code});
      chk("irq", {7'h00, |(st & en)}, {7'h00, o_irq});
      wr(`SA6_OFS_STATUS, 8'hff);
      wr(`SA6_OFS_CLEAR, 8'h01);
      st = st & 8'hfe;
      rd(`SA6_OFS_STATUS, st);
      st = 8'h00;
      rd(`SA6_OFS_STATUS, 8'h00);
      repeat (3) @(posedge i_clk);
      #1;
      chk("irq", 8'h00, {7'h00, o_irq});
      $display("test code %h done", new_c);
    end
    close_out();
  end
endmodule // test_e1_sa6_pattern_change_irq
`default_nettype wire
